//--- verilog/tsis_pkg.sv
// constants, states and carrier types of the two-wire sensor slave port
package tsis_pkg;
    // timing
    localparam int CLK_HZ = 20_000_000;
    localparam int TIMEOUT_MS = 30;
    localparam int TIMEOUT_CYCLES = TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int TMO_W = 20;
    // strap pin connection codes, then the settle counts for strap capture and settle done
    localparam logic [1:0] STRAP_LOW = 2'h0;
    localparam logic [1:0] STRAP_HIGH = 2'h1;
    localparam logic [1:0] STRAP_DATA = 2'h2;
    localparam logic [1:0] STRAP_CLOCK = 2'h3;
    localparam logic [1:0] STRAP_TAKE = 2'h2;
    localparam logic [1:0] SETTLE_DONE = 2'h3;
    // address bases
    localparam logic [6:0] ADDR_BASE_CLK = 7'h44;
    localparam logic [6:0] ADDR_BASE_STD = 7'h48;
    // index of the temperature reading register
    localparam logic [7:0] TEMP_INDEX = 8'h00;
    // byte framing
    localparam logic [2:0] LAST_BIT = 3'h7;
    // alert flag after reset
    localparam logic FLAG_RESET = 1'h1;
    // sync reset values
    localparam logic [1:0] BUS_IDLE = 2'h3;
    localparam logic [3:0] STRAP_RST = 4'h0;
    // write fifo depth
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
        ST_WDATA, ST_DATA_ACK, ST_RDATA, ST_RACK, ST_WAIT
    } tsis_state_t;

    // one received data byte bound for the register bank
    typedef struct packed {
        logic [7:0] index;
        logic lsb;
        logic [7:0] data;
    } tsis_wr_t;

    localparam int WR_WIDTH = $bits(tsis_wr_t);
endpackage : tsis_pkg

//--- verilog/tsis_sync.sv
// two flip-flop synchroniser, one chain per bit
`timescale 1ns/10ps
module tsis_sync #(
    parameter int W = 2,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta;

    // first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk_in) begin
                if (rst_in) begin
                    meta[i] <= RST_VAL[i];
                    sync_out[i] <= RST_VAL[i];
                end else begin
                    meta[i] <= async_in[i];
                    sync_out[i] <= meta[i];
                end
            end
        end
    endgenerate
endmodule : tsis_sync

//--- verilog/tsis_fifo.sv
// small valid/ready fifo with parameter width and depth
`timescale 1ns/10ps
module tsis_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic wr;
    logic rd;

    // honest full and empty
    assign in_ready_out = (cnt != FULL);
    assign out_valid_out = (cnt != '0);
    assign out_data_out = mem[rp];
    assign wr = in_valid_in & in_ready_out;
    assign rd = out_valid_out & out_ready_in;

    // storage
    always_ff @(posedge clk_in) begin
        if (wr) begin
            mem[wp] <= in_data_in;
        end
    end

    // pointers and fill count
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            if (wr) begin
                wp <= (wp == LAST) ? '0 : wp + AW'(1);
            end
            if (rd) begin
                rp <= (rp == LAST) ? '0 : rp + AW'(1);
            end
            cnt <= cnt + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
        end
    end
endmodule : tsis_fifo

//--- verilog/tsis_slave_port.sv
// two-wire slave port of the temperature sensor: framing, index, alert flag
`timescale 1ns/10ps
module tsis_slave_port #(
    parameter int TIMEOUT_CYC = tsis_pkg::TIMEOUT_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic [1:0] slave_id_strap_a_in,
    input wire logic [1:0] slave_id_strap_b_in,
    output logic [6:0] own_addr_out,
    output logic alert_enable_out,
    input wire logic latched_interrupt_style_in,
    input wire logic alert_sense_invert_in,
    input wire logic upper_limit_hit_in,
    input wire logic lower_limit_hit_in,
    output logic alert_cond_flag_out,
    output logic alert_out,
    output logic alert_oe_out,
    output logic [7:0] reg_index_out,
    input wire logic [15:0] rd_word_in,
    output logic wr_valid_out,
    input wire logic wr_ready_in,
    output tsis_pkg::tsis_wr_t wr_data_out,
    output logic busy_out
);
    import tsis_pkg::*;
    localparam logic [TMO_W-1:0] TMO_MAX = TMO_W'(TIMEOUT_CYC - 1);
    logic scl_s, sda_s, scl_d, sda_d;
    logic scl_rise, scl_fall, start_det, stop_det, tmo, byte_end;
    logic [3:0] strap_s;
    logic [1:0] strap_a, strap_b, settle;
    logic [TMO_W-1:0] tmo_cnt;
    tsis_state_t state;
    logic [7:0] shreg, tx;
    logic [2:0] bit_cnt;
    logic byte_done, rw, rd_lsb, wr_lsb, acked;
    logic [15:0] word;
    logic in_ready, push, alerted, next_alerted;
    tsis_wr_t push_data;
    // bus pins and straps into the clock domain
    tsis_sync #(.W(2), .RST_VAL(BUS_IDLE)) u_bus_sync (
        .clk_in(ref_clk_in),
        .rst_in(sys_rst_in),
        .async_in({scl_in, sda_in}),
        .sync_out({scl_s, sda_s})
    );
    tsis_sync #(.W(4), .RST_VAL(STRAP_RST)) u_strap_sync (
        .clk_in(ref_clk_in),
        .rst_in(sys_rst_in),
        .async_in({slave_id_strap_a_in, slave_id_strap_b_in}),
        .sync_out(strap_s)
    );
    // delayed copies for edge detection
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end
    // clock edges and bus conditions; oversampling limits usable rate
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign start_det = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_det = scl_s & scl_d & ~sda_d & sda_s;
    assign byte_end = scl_fall & byte_done;
    // straps caught once the synchroniser has settled after reset
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            settle <= 2'h0;
            strap_a <= STRAP_LOW;
            strap_b <= STRAP_LOW;
        end else begin
            if (settle != SETTLE_DONE) begin
                settle <= settle + 2'h1;
            end
            if (settle == STRAP_TAKE) begin
                strap_a <= strap_s[3:2];
                strap_b <= strap_s[1:0];
            end
        end
    end
    // own address and alert enable from the straps
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            own_addr_out <= ADDR_BASE_STD;
            alert_enable_out <= 1'b0;
        end else begin
            own_addr_out <= ((strap_a == STRAP_CLOCK) ? ADDR_BASE_CLK : ADDR_BASE_STD)
                | {5'h00, strap_b};
            alert_enable_out <= (strap_a == STRAP_HIGH);
        end
    end
    // stuck-low clock watchdog
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || scl_s) begin
            tmo_cnt <= '0;
        end else if (tmo_cnt != TMO_MAX) begin
            tmo_cnt <= tmo_cnt + TMO_W'(1);
        end
    end
    assign tmo = (tmo_cnt == TMO_MAX);
    // protocol engine: framing, acknowledge and transmit shifting
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            state <= ST_IDLE;
            sda_oe_out <= 1'b0;
            bit_cnt <= 3'h0;
            byte_done <= 1'b0;
            shreg <= 8'h00;
            tx <= 8'h00;
            rw <= 1'b0;
            rd_lsb <= 1'b0;
            acked <= 1'b0;
            word <= 16'h0000;
        end else if (tmo || stop_det) begin
            state <= ST_IDLE;
            sda_oe_out <= 1'b0;
            byte_done <= 1'b0;
        end else if (start_det) begin
            state <= ST_ADDR;
            sda_oe_out <= 1'b0;
            bit_cnt <= 3'h0;
            byte_done <= 1'b0;
        end else begin
            case (state)
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (scl_rise) begin
                        shreg <= {shreg[6:0], sda_s};
                        bit_cnt <= bit_cnt + 3'h1;
                        byte_done <= (bit_cnt == LAST_BIT);
                    end else if (byte_end) begin
                        byte_done <= 1'b0;
                        bit_cnt <= 3'h0;
                        if (state == ST_ADDR) begin
                            if (shreg[7:1] == own_addr_out) begin
                                rw <= shreg[0];
                                sda_oe_out <= 1'b1;
                                state <= ST_ADDR_ACK;
                            end else begin
                                state <= ST_WAIT;
                            end
                        end else if (state == ST_PTR) begin
                            sda_oe_out <= 1'b1;
                            state <= ST_PTR_ACK;
                        end else if (in_ready) begin
                            sda_oe_out <= 1'b1;
                            state <= ST_DATA_ACK;
                        end else begin
                            state <= ST_WAIT;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (rw) begin
                            word <= rd_word_in;
                            tx <= rd_word_in[15:8];
                            sda_oe_out <= ~rd_word_in[15];
                            rd_lsb <= 1'b1;
                            state <= ST_RDATA;
                        end else begin
                            sda_oe_out <= 1'b0;
                            state <= ST_PTR;
                        end
                    end
                end
                ST_PTR_ACK, ST_DATA_ACK: begin
                    if (scl_fall) begin
                        sda_oe_out <= 1'b0;
                        state <= ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        if (bit_cnt == LAST_BIT) begin
                            sda_oe_out <= 1'b0;
                            bit_cnt <= 3'h0;
                            acked <= 1'b0;
                            state <= ST_RACK;
                        end else begin
                            tx <= {tx[6:0], 1'b0};
                            sda_oe_out <= ~tx[6];
                            bit_cnt <= bit_cnt + 3'h1;
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        if (sda_s) begin
                            state <= ST_WAIT;
                        end else begin
                            acked <= 1'b1;
                        end
                    end else if (scl_fall && acked) begin
                        tx <= rd_lsb ? word[7:0] : word[15:8];
                        sda_oe_out <= rd_lsb ? ~word[7] : ~word[15];
                        rd_lsb <= ~rd_lsb;
                        acked <= 1'b0;
                        state <= ST_RDATA;
                    end
                end
                default: begin
                    sda_oe_out <= 1'b0;
                end
            endcase
        end
    end
    // index register; reset selects the temperature reading
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            reg_index_out <= TEMP_INDEX;
        end else if (state == ST_PTR && byte_end) begin
            reg_index_out <= shreg;
        end
    end
    // upper/lower byte order of written data
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            wr_lsb <= 1'b0;
        end else if (state == ST_PTR_ACK) begin
            wr_lsb <= 1'b0;
        end else if (push) begin
            wr_lsb <= ~wr_lsb;
        end
    end
    // received data bytes into the write fifo
    assign push = (state == ST_WDATA) && byte_end && in_ready;
    assign push_data = '{index: reg_index_out, lsb: wr_lsb, data: shreg};
    tsis_fifo #(.WIDTH(WR_WIDTH), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
        .clk_in(ref_clk_in),
        .rst_in(sys_rst_in),
        .in_valid_in(push),
        .in_ready_out(in_ready),
        .in_data_in(push_data),
        .out_valid_out(wr_valid_out),
        .out_ready_in(wr_ready_in),
        .out_data_out(wr_data_out)
    );
    // alert condition tracking and sensed flag
    assign next_alerted = upper_limit_hit_in ? 1'b1 : (lower_limit_hit_in ? 1'b0 : alerted);
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            alerted <= 1'b0;
            alert_cond_flag_out <= FLAG_RESET;
        end else begin
            alerted <= next_alerted;
            alert_cond_flag_out <= ~(next_alerted ^ alert_sense_invert_in);
        end
    end
    // open-drain pins: data only ever pulled low, clock never driven
    assign sda_out = 1'b0;
    assign alert_out = alert_cond_flag_out;
    assign alert_oe_out = alert_enable_out & latched_interrupt_style_in;
    assign busy_out = (state != ST_IDLE);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    a_start_to_addr: assert property (
        start_det && !stop_det && !tmo |=> state == ST_ADDR && !sda_oe_out)
        else $error("start not taken");
    a_stop_release: assert property (
        stop_det |=> state == ST_IDLE && !sda_oe_out)
        else $error("stop did not release");
    a_ack_on_match: assert property (
        state == ST_ADDR && byte_end && !start_det && !stop_det && !tmo
        && shreg[7:1] == own_addr_out |=> sda_oe_out && state == ST_ADDR_ACK)
        else $error("matching address not acked");
    a_foreign_addr: assert property (
        state == ST_ADDR && byte_end && !start_det && !stop_det && !tmo
        && shreg[7:1] != own_addr_out |=> (state == ST_WAIT && !sda_oe_out) [*2])
        else $error("foreign address driven");
    a_oe_on_low: assert property (
        $changed(sda_oe_out) |-> $past(scl_fall || start_det || stop_det || tmo))
        else $error("data changed outside clock low");
    a_rise_sample: assert property (
        state == ST_ADDR && scl_rise && !start_det && !stop_det && !tmo
        |=> shreg[0] == $past(sda_s) && shreg[7:1] == $past(shreg[6:0]))
        else $error("bit not sampled at rise");
    a_index_load: assert property (
        state == ST_PTR && byte_end |=> reg_index_out == $past(shreg))
        else $error("index not loaded");
    a_index_hold: assert property (
        !(state == ST_PTR && byte_end) |=> $stable(reg_index_out))
        else $error("index changed");
    a_msb_first: assert property (
        state == ST_ADDR_ACK && rw && scl_fall && !start_det && !stop_det && !tmo
        |=> sda_oe_out == !$past(rd_word_in[15]) && tx == $past(rd_word_in[15:8]))
        else $error("upper byte not first");
    a_nack_release: assert property (
        state == ST_RACK && scl_rise && sda_s && !start_det && !stop_det && !tmo
        |=> state == ST_WAIT && !sda_oe_out)
        else $error("nack did not end read");
    a_timeout_reset: assert property (
        tmo |=> state == ST_IDLE && !sda_oe_out)
        else $error("timeout did not reset port");
    a_alert_sense: assert property (
        upper_limit_hit_in |=> alert_cond_flag_out == $past(alert_sense_invert_in))
        else $error("alert flag sense wrong");
    a_addr_map: assert property (
        settle == SETTLE_DONE && $stable(strap_a) && $stable(strap_b) |=>
        own_addr_out[6:2] == ((strap_a == STRAP_CLOCK) ? 5'h11 : 5'h12)
        && own_addr_out[1:0] == strap_b)
        else $error("address map wrong");
endmodule : tsis_slave_port

//--- tb/tsis_master_model.sv
// bus master model driving clock and data of the two-wire link
`timescale 1ns/10ps
module tsis_master_model (
    input wire logic ref_clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_oe_out
);
    // idle: clock driven high, data left to the pull-up
    initial begin
        scl_out = 1'h1;
        sda_oe_out = 1'h0;
    end

    // one bit: data moves only with clock low, read late in the high phase
    task automatic bit_io(input logic b, output logic s);
        #25 sda_oe_out = ~b;
        #175 scl_out = 1'h1;
        #175 s = sda_in;
        #25 scl_out = 1'h0;
    endtask : bit_io

    // one byte, most significant bit first, then the ninth bit
    task automatic xfer(input logic [7:0] d, input logic k, output logic [7:0] q,
                        output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(k, ack);
    endtask : xfer

    // data falls with clock high, also as repeated start
    task automatic start();
        @(negedge ref_clk_in);
        #7 sda_oe_out = 1'h0;
        #200 scl_out = 1'h1;
        #200 sda_oe_out = 1'h1;
        #200 scl_out = 1'h0;
    endtask : start

    // data rises with clock high, bus left idle
    task automatic stop();
        @(negedge ref_clk_in);
        #7 sda_oe_out = 1'h1;
        #200 scl_out = 1'h1;
        #200 sda_oe_out = 1'h0;
        #200;
    endtask : stop
endmodule : tsis_master_model

//--- tb/tb_tsis_slave_port.sv
// self-checking bench of the sensor slave port
`timescale 1ns/10ps
module tb_tsis_slave_port;
    import tsis_pkg::*;
    localparam logic [6:0] ME = 7'h49;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic scl, sda, m_oe, d_oe, a, en, flag, al, al_oe, wv, busy, so;
    logic style = 1'h0;
    logic inv = 1'h0;
    logic up = 1'h0;
    logic lo = 1'h0;
    logic rdy = 1'h0;
    logic [1:0] sa = 2'h0;
    logic [1:0] sb = 2'h0;
    logic [6:0] addr;
    logic [7:0] idx, q;
    tsis_wr_t wd;
    int bad_count = 0;
    int checks_done = 0;

    // open-drain data line with pull-up
    assign sda = ~(d_oe | m_oe);

    // system clock, 50 ns
    always #25 clk = ~clk;

    // register bank stand-in: upper byte of the word follows the index
    tsis_slave_port #(.TIMEOUT_CYC(200)) tsis_slave_port_i (
        .ref_clk_in(clk), .sys_rst_in(rst), .scl_in(scl), .sda_in(sda),
        .sda_out(so), .sda_oe_out(d_oe), .slave_id_strap_a_in(sa),
        .slave_id_strap_b_in(sb), .own_addr_out(addr), .alert_enable_out(en),
        .latched_interrupt_style_in(style), .alert_sense_invert_in(inv),
        .upper_limit_hit_in(up), .lower_limit_hit_in(lo),
        .alert_cond_flag_out(flag), .alert_out(al), .alert_oe_out(al_oe),
        .reg_index_out(idx), .rd_word_in({idx ^ 8'hC3, 8'hDA}), .wr_valid_out(wv),
        .wr_ready_in(rdy), .wr_data_out(wd), .busy_out(busy)
    );

    tsis_master_model mst (.ref_clk_in(clk), .sda_in(sda), .scl_out(scl),
        .sda_oe_out(m_oe));

    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    // verdict and end of run
    task automatic end_sim();
        $display("mismatches %0d comparisons %0d", bad_count, checks_done);
        if (bad_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    // reset for five cycles, then let straps settle
    task automatic reset();
        rst = 1'h1;
        repeat (5) @(negedge clk);
        rst = 1'h0;
        repeat (10) @(negedge clk);
    endtask : reset

    // start and address byte
    task automatic go(input logic rd);
        mst.start();
        mst.xfer({ME, rd}, 1'h1, q, a);
    endtask : go

    // take one fifo head and compare it
    task automatic pop(input logic l, input logic [7:0] d);
        chk(wv, 1'h1);
        chk(wd, {8'h03, l, d});
        @(negedge clk) rdy = 1'h1;
        @(negedge clk) rdy = 1'h0;
    endtask : pop

    // watchdog
    initial begin
        #3_000_000;
        bad_count++;
        end_sim();
    end

    // test sequence
    initial begin
        // every strap code pair
        for (int i = 0; i < 16; i++) begin
            sa = i[3:2];
            sb = i[1:0];
            reset();
            chk(addr, (sa == STRAP_CLOCK ? 7'h44 : 7'h48) + {5'h0, sb});
            chk(en, sa == STRAP_HIGH);
        end
        chk(idx, 8'h00);
        chk({flag, wv, busy, d_oe}, 4'h8);
        chk(so, 1'h0);
        sa = 2'h1;
        sb = 2'h1;
        reset();
        // foreign address and its data byte left unanswered
        mst.start();
        mst.xfer({7'h4B, 1'h0}, 1'h1, q, a);
        chk(a, 1'h1);
        mst.xfer(8'h00, 1'h1, q, a);
        chk(a, 1'h1);
        mst.stop();
        // pointer then nine bytes into an eight deep buffer
        go(1'h0);
        chk(a, 1'h0);
        mst.xfer(8'h03, 1'h1, q, a);
        chk(a, 1'h0);
        chk(idx, 8'h03);
        for (int i = 0; i < 9; i++) begin
            mst.xfer(8'h11 * i[7:0], 1'h1, q, a);
            chk(a, i == 8);
        end
        mst.stop();
        chk(busy, 1'h0);
        for (int i = 0; i < 8; i++) begin
            pop(i[0], 8'h11 * i[7:0]);
        end
        chk(wv, 1'h0);
        // pointer zero, repeated start, full word read
        go(1'h0);
        mst.xfer(8'h00, 1'h1, q, a);
        go(1'h1);
        chk(a, 1'h0);
        chk(idx, 8'h00);
        mst.xfer(8'hFF, 1'h0, q, a);
        chk(q, 8'hC3);
        mst.xfer(8'hFF, 1'h1, q, a);
        chk(q, 8'hDA);
        chk(d_oe, 1'h0);
        mst.stop();
        // same index read again, cut by a stop after the upper byte
        go(1'h1);
        mst.xfer(8'hFF, 1'h0, q, a);
        chk(q, 8'hC3);
        mst.stop();
        chk({busy, d_oe}, 2'h0);
        // clock held low during the address acknowledge
        mst.start();
        for (int i = 7; i >= 0; i--) begin
            mst.bit_io(i > 0 ? ME[i - 1] : 1'h0, a);
        end
        repeat (8) @(negedge clk);
        chk(d_oe, 1'h1);
        repeat (250) @(negedge clk);
        chk({busy, d_oe}, 2'h0);
        mst.stop();
        // alert flag under both senses
        @(negedge clk) style = 1'h1;
        for (int i = 0; i < 2; i++) begin
            @(negedge clk) inv = i[0];
            up = 1'h1;
            repeat (2) @(negedge clk);
            up = 1'h0;
            chk(flag, i[0]);
            lo = 1'h1;
            repeat (2) @(negedge clk);
            lo = 1'h0;
            chk({flag, al}, {2{~i[0]}});
        end
        chk(al_oe, 1'h1);
        @(negedge clk) style = 1'h0;
        #1 chk(al_oe, 1'h0);
        end_sim();
    end
endmodule : tb_tsis_slave_port
